// ### cac_map.svh
// register offsets, field positions and reset values of the alarm compare block
`ifndef CAC_MAP_SVH
`define CAC_MAP_SVH

`define CAC_OFF_ALARM_SECONDS 8'h10
`define CAC_OFF_ALARM_MINUTES 8'h11
`define CAC_OFF_ALARM_HOURS 8'h12
`define CAC_OFF_ALARM_DAY 8'h13
`define CAC_OFF_ALARM_WEEKDAY 8'h14
`define CAC_OFF_ALARM_MONTH 8'h15
`define CAC_OFF_ALARM_YEAR 8'h16
`define CAC_OFF_CONTROL 8'h01
`define CAC_OFF_STATUS 8'h02
`define CAC_OFF_MASK 8'h03

`define CAC_ENABLE_BIT 7
`define CAC_ENABLE_MASK 8'h80
`define CAC_SEC_MASK 8'h7f
`define CAC_MIN_MASK 8'h7f
`define CAC_HOUR_MASK 8'h3f
`define CAC_DAY_MASK 8'h3f
`define CAC_WDAY_MASK 8'h07
`define CAC_MON_MASK 8'h1f
`define CAC_YEAR_MASK 8'h7f
`define CAC_AIE_BIT 0
`define CAC_AF_BIT 0
`define CAC_H12_BIT 1
`define CAC_FIELD_COUNT 7
`define CAC_ALARM_RESET 8'h00

`endif

// ### cac_pkg.sv
// types shared by the alarm compare block
package cac_pkg;
    // current time and date, bcd
    typedef struct packed {
        logic [6:0] seconds;
        logic [6:0] minutes;
        logic [5:0] hours;
        logic [5:0] day;
        logic [2:0] weekday;
        logic [4:0] month;
        logic [6:0] year;
    } cac_time_t;

    // one alarm target byte per field
    typedef logic [7:0] cac_byte_t;
endpackage

// ### cac_cmp_if.sv
// interface carrying alarm targets and current time to the comparator
`timescale 1ns/100ps
`default_nettype none
interface cac_cmp_if;
    cac_pkg::cac_byte_t targets [7];  // alarm registers as stored
    cac_pkg::cac_time_t now;          // current counters
    logic allMatch;                   // every enabled field equal
    logic anyEnabled;                 // at least one field enabled

    modport regs (output targets, output now, input allMatch, input anyEnabled);
    modport cmp (input targets, input now, output allMatch, output anyEnabled);
endinterface
`default_nettype wire

// ### cac_compare.sv
// combinational field compare of alarm targets against current time
`timescale 1ns/100ps
`default_nettype none
`include "cac_map.svh"
module cac_compare (
    cac_cmp_if.cmp cmp
);
    // field match gated by its enable
    function automatic logic fieldOk(input logic [7:0] t, input logic [7:0] c,
                                     input logic [7:0] m);
        fieldOk = !t[`CAC_ENABLE_BIT] || ((t & m) == (c & m));
    endfunction

    logic [6:0] ok;
    logic [6:0] en;

    // each enabled field compared, disabled ones forced true
    always_comb begin
        ok[0] = fieldOk(cmp.targets[0], {1'b0, cmp.now.seconds}, `CAC_SEC_MASK);
        ok[1] = fieldOk(cmp.targets[1], {1'b0, cmp.now.minutes}, `CAC_MIN_MASK);
        ok[2] = fieldOk(cmp.targets[2], {2'b00, cmp.now.hours}, `CAC_HOUR_MASK);
        ok[3] = fieldOk(cmp.targets[3], {2'b00, cmp.now.day}, `CAC_DAY_MASK);
        ok[4] = fieldOk(cmp.targets[4], {5'b00000, cmp.now.weekday}, `CAC_WDAY_MASK);
        ok[5] = fieldOk(cmp.targets[5], {3'b000, cmp.now.month}, `CAC_MON_MASK);
        ok[6] = fieldOk(cmp.targets[6], {1'b0, cmp.now.year}, `CAC_YEAR_MASK);
        for (int i = 0; i < 7; i++) begin
            en[i] = cmp.targets[i][`CAC_ENABLE_BIT];
        end
    end

    // disabled fields excluded by forcing them true
    assign cmp.allMatch = &ok;
    assign cmp.anyEnabled = |en;
endmodule
`default_nettype wire

// ### cac_regfile.sv
// alarm target storage with write mask of unused bits
`timescale 1ns/100ps
`default_nettype none
`include "cac_map.svh"
module cac_regfile (
    input wire logic clock,
    input wire logic rst,
    input wire logic wrEn,
    input wire logic [2:0] wrIdx,
    input wire logic [7:0] wrData,
    input wire logic [2:0] rdIdx,
    output logic [7:0] rdValue,
    cac_cmp_if.regs link,
    input wire cac_pkg::cac_time_t nowIn
);
    // used bits of each alarm register, enable bit included
    function automatic logic [7:0] keepMask(input logic [2:0] idx);
        unique case (idx)
            3'h0: keepMask = `CAC_ENABLE_MASK | `CAC_SEC_MASK;
            3'h1: keepMask = `CAC_ENABLE_MASK | `CAC_MIN_MASK;
            3'h2: keepMask = `CAC_ENABLE_MASK | `CAC_HOUR_MASK;
            3'h3: keepMask = `CAC_ENABLE_MASK | `CAC_DAY_MASK;
            3'h4: keepMask = `CAC_ENABLE_MASK | `CAC_WDAY_MASK;
            3'h5: keepMask = `CAC_ENABLE_MASK | `CAC_MON_MASK;
            3'h6: keepMask = `CAC_ENABLE_MASK | `CAC_YEAR_MASK;
            default: keepMask = 8'h00;
        endcase
    endfunction

    typedef struct packed {
        logic [6:0][7:0] alarm; // stored targets
    } cac_rf_state_t;

    cac_rf_state_t state_reg;
    cac_rf_state_t state_next;

    // write updates only used bits
    always_comb begin
        state_next = state_reg;
        if (wrEn && wrIdx < 3'h7) begin
            state_next.alarm[wrIdx] = wrData & keepMask(wrIdx);
        end
    end

    // register the state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // read value, zero beyond the alarm page
    always_comb begin
        rdValue = (rdIdx < 3'h7) ? state_reg.alarm[rdIdx] : 8'h00;
        for (int i = 0; i < 7; i++) begin
            link.targets[i] = state_reg.alarm[i];
        end
        link.now = nowIn;
    end
endmodule
`default_nettype wire

// ### cac_alarm_top.sv
// alarm page of a real time clock: registers, compare, flag and interrupt
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "cac_map.svh"
module cac_alarm_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [7:0] rdData,
    input wire cac_pkg::cac_time_t nowTime,
    input wire logic nowTick,
    output logic irq,
    output logic alarmFlag,
    output logic hourMode12
);
    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [7:0] rdData;     // read answer
        logic intEnable;        // alarm_interrupt_enable
        logic h12;              // 12-hour layout selected
        logic flag;             // alarm_flag sticky status
        logic mask;             // interrupt mask
        logic prevMatch;        // match seen at the last counter tick
        logic irq;              // interrupt output
    } cac_top_state_t;

    cac_top_state_t state_reg;
    cac_top_state_t state_next;

    logic [7:0] alarmRd;  // regfile read value
    logic matchNow;       // qualified full match
    logic alarmWr;        // write to alarm page
    logic [2:0] wrIdx;    // alarm index of write
    logic [2:0] rdIdx;    // alarm index of read

    cac_cmp_if cmpBus ();

    ////////////////////////////////////////////////////////////////////////
    // address decode
    function automatic logic inAlarm(input logic [7:0] a);
        inAlarm = a >= `CAC_OFF_ALARM_SECONDS && a <= `CAC_OFF_ALARM_YEAR;
    endfunction

    always_comb begin
        alarmWr = wrStrobe && inAlarm(addr);
        wrIdx = inAlarm(addr) ? 3'(addr - `CAC_OFF_ALARM_SECONDS) : 3'h7;
        rdIdx = wrIdx;
    end

    ////////////////////////////////////////////////////////////////////////
    // storage and compare
    cac_regfile u_regs (
        .clock(clock),
        .rst(rst),
        .wrEn(alarmWr),
        .wrIdx(wrIdx),
        .wrData(wrData),
        .rdIdx(rdIdx),
        .rdValue(alarmRd),
        .link(cmpBus.regs),
        .nowIn(nowTime)
    );

    cac_compare u_cmp (
        .cmp(cmpBus.cmp)
    );

    // bcd hour compare is bitwise so both layouts share it; pm bit is bit 5
    // in 12h and tens-of-twenty in 24h, held identically in counter and target
    assign matchNow = cmpBus.allMatch && cmpBus.anyEnabled;

    ////////////////////////////////////////////////////////////////////////
    // next state: bus, flag, interrupt
    always_comb begin
        state_next = state_reg;
        state_next.rdData = 8'h00;
        // match edge tracked on counter updates only
        if (nowTick) begin
            state_next.prevMatch = matchNow;
        end
        // control register write
        if (wrStrobe && addr == `CAC_OFF_CONTROL) begin
            state_next.intEnable = wrData[`CAC_AIE_BIT];
            state_next.h12 = wrData[`CAC_H12_BIT];
        end
        if (wrStrobe && addr == `CAC_OFF_MASK) begin
            state_next.mask = wrData[`CAC_AF_BIT];
        end
        // write one clears the flag
        if (wrStrobe && addr == `CAC_OFF_STATUS && wrData[`CAC_AF_BIT]) begin
            state_next.flag = 1'b0;
        end
        // first match sets flag while interrupt enabled, set beats clear
        if (nowTick && matchNow && !state_reg.prevMatch && state_reg.intEnable) begin
            state_next.flag = 1'b1;
        end
        // read mux
        if (rdStrobe) begin
            if (inAlarm(addr)) begin
                state_next.rdData = alarmRd;
            end else if (addr == `CAC_OFF_CONTROL) begin
                state_next.rdData = {6'h00, state_reg.h12, state_reg.intEnable};
            end else if (addr == `CAC_OFF_STATUS) begin
                state_next.rdData = {7'h00, state_reg.flag};
            end else if (addr == `CAC_OFF_MASK) begin
                state_next.rdData = {7'h00, state_reg.mask};
            end
        end
        state_next.irq = state_next.flag && state_next.mask;
    end

    // register the state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdData = state_reg.rdData;
    assign irq = state_reg.irq;
    assign alarmFlag = state_reg.flag;
    assign hourMode12 = state_reg.h12;

    ////////////////////////////////////////////////////////////////////////
    // checks
    flag_sets_a: assert property (@(posedge clock) disable iff (rst)
        nowTick && matchNow && !state_reg.prevMatch && state_reg.intEnable |=> alarmFlag)
        else $error("flag not set on first match");
    no_aie_a: assert property (@(posedge clock) disable iff (rst)
        !alarmFlag && !state_reg.intEnable && !(wrStrobe && addr == `CAC_OFF_STATUS)
        |=> !alarmFlag)
        else $error("flag set without interrupt enable");
    irq_follow_a: assert property (@(posedge clock) disable iff (rst)
        irq == (alarmFlag && state_reg.mask))
        else $error("irq differs from masked flag");
    disabled_ok_a: assert property (@(posedge clock) disable iff (rst)
        !cmpBus.targets[0][7] && !cmpBus.targets[1][7] && !cmpBus.targets[2][7]
        && !cmpBus.targets[3][7] && !cmpBus.targets[4][7] && !cmpBus.targets[5][7]
        && !cmpBus.targets[6][7] |-> !matchNow)
        else $error("match with all fields disabled");
    sec_cmp_a: assert property (@(posedge clock) disable iff (rst)
        cmpBus.targets[0][7] && cmpBus.targets[0][6:0] != nowTime.seconds |-> !matchNow)
        else $error("seconds mismatch ignored");
    hour_cmp_a: assert property (@(posedge clock) disable iff (rst)
        cmpBus.targets[2][7] && cmpBus.targets[2][5:0] != nowTime.hours |-> !matchNow)
        else $error("hours mismatch ignored");
    read_back_a: assert property (@(posedge clock) disable iff (rst)
        wrStrobe && addr == `CAC_OFF_ALARM_WEEKDAY ##1 rdStrobe
        && addr == `CAC_OFF_ALARM_WEEKDAY |=> rdData == ($past(wrData, 2) & 8'h87))
        else $error("weekday read back wrong");
    year_back_a: assert property (@(posedge clock) disable iff (rst)
        wrStrobe && addr == `CAC_OFF_ALARM_YEAR ##1 rdStrobe
        && addr == `CAC_OFF_ALARM_YEAR |=> rdData == $past(wrData, 2))
        else $error("year read back wrong");
    clear_a: assert property (@(posedge clock) disable iff (rst)
        wrStrobe && addr == `CAC_OFF_STATUS && wrData[0] && !nowTick |=> !alarmFlag)
        else $error("flag not cleared");

    alarm_fire_c: cover property (@(posedge clock) disable iff (rst) $rose(alarmFlag));
    irq_c: cover property (@(posedge clock) disable iff (rst) $rose(irq));
    clear_c: cover property (@(posedge clock) disable iff (rst) $fell(alarmFlag));
endmodule
`default_nettype wire

// ### cac_host_model.sv
// host controller model driving the alarm register port
`timescale 1ns/100ps
`default_nettype none
module cac_host_model (
    input wire logic clock,
    output logic [7:0] addr,
    output logic [7:0] wrData,
    output logic wrStrobe,
    output logic rdStrobe
);
    // quiet bus at time zero
    initial begin
        addr = 8'h00;
        wrData = 8'h00;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one write cycle, entered just after a rising edge
    task automatic busWrite(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        rdStrobe <= 1'b0;
        @(posedge clock);
    endtask

    // one read cycle; data is not qualified, so it toggles
    task automatic busRead(input logic [7:0] a);
        addr <= a;
        wrData <= ~wrData;
        wrStrobe <= 1'b0;
        rdStrobe <= 1'b1;
        @(posedge clock);
    endtask

    // release both strobes for one cycle
    task automatic busIdle();
        wrData <= ~wrData;
        wrStrobe <= 1'b0;
        rdStrobe <= 1'b0;
        @(posedge clock);
    endtask
endmodule
`default_nettype wire

// ### cac_alarm_top_bench.sv
// self-checking bench of the alarm compare block
`timescale 1ns/100ps
`default_nettype none
`include "cac_map.svh"
module cac_alarm_top_bench;
    logic clock;
    logic rst;
    logic [7:0] addr;
    logic [7:0] wrData;
    logic wrStrobe;
    logic rdStrobe;
    logic [7:0] rdData;
    cac_pkg::cac_time_t nowTime;
    logic nowTick;
    logic irq;
    logic alarmFlag;
    logic hourMode12;
    logic [7:0] expQ [$]; // expected read data, oldest first
    logic rdSeen = 1'b0; // read strobe of the previous edge
    logic [31:0] seed;
    logic [7:0] vals [7];
    int err_total;
    int compares;
    // stored bits per register: enable plus target field
    localparam logic [7:0] KEEP [7] = '{8'hff, 8'hff, 8'hbf, 8'hbf, 8'h87, 8'h9f, 8'hff};
    // hour 0x21 is 1 pm in the 12-hour layout and 21 in the 24-hour one
    localparam cac_pkg::cac_time_t HIT = '{7'h30, 7'h45, 6'h21, 6'h17, 3'h3, 5'h09, 7'h24};
    localparam cac_pkg::cac_time_t MISS = '{7'h30, 7'h44, 6'h21, 6'h17, 3'h3, 5'h09, 7'h24};

    cac_alarm_top i_cac_alarm_top (.clock(clock), .rst(rst), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .nowTime(nowTime),
        .nowTick(nowTick), .irq(irq), .alarmFlag(alarmFlag), .hourMode12(hourMode12));
    cac_host_model i_cac_host_model (.clock(clock), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe));

    ////////////////////////////////////////////////////////////////////////////
    always #4 clock = ~clock;

    // xorshift step for random register data
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] r;
        r = v ^ (v << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic end_of_test();
        if (expQ.size() != 0) begin
            err_total++;
        end
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // read data stands only the cycle after the strobe
    always @(posedge clock) begin
        rdSeen <= rdStrobe;
        if (rdSeen) begin
            check(rdData, (expQ.size() > 0) ? expQ.pop_front() : 8'hxx, "read");
        end
    end

    task automatic expRead(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        i_cac_host_model.busRead(a);
    endtask

    // counters update with a one-cycle tick; flag is sampled one edge later
    task automatic tick(input cac_pkg::cac_time_t t);
        nowTime <= t;
        nowTick <= 1'b1;
        @(posedge clock);
        nowTick <= 1'b0;
        @(posedge clock);
    endtask

    // miss, first hit, held hit after clear
    task automatic alarmRun(input logic [7:0] ctl, input logic [7:0] msk, input logic ef,
        input logic ei);
        i_cac_host_model.busWrite(`CAC_OFF_CONTROL, ctl);
        i_cac_host_model.busWrite(`CAC_OFF_MASK, msk);
        i_cac_host_model.busWrite(`CAC_OFF_STATUS, 8'h01);
        i_cac_host_model.busIdle();
        tick(MISS);
        check({7'h00, alarmFlag}, 8'h00, "flag on miss");
        check({7'h00, hourMode12}, {7'h00, ctl[1]}, "hour layout");
        tick(HIT);
        check({7'h00, alarmFlag}, {7'h00, ef}, "flag on hit");
        check({7'h00, irq}, {7'h00, ei}, "irq on hit");
        expRead(`CAC_OFF_STATUS, {7'h00, ef});
        i_cac_host_model.busWrite(`CAC_OFF_STATUS, 8'h01);
        expRead(`CAC_OFF_CONTROL, ctl & 8'h03);
        i_cac_host_model.busIdle();
        tick(HIT);
        check({7'h00, alarmFlag}, 8'h00, "held match");
        $display("alarm run ctl %h mask %h done", ctl, msk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // bounded run
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        $display("MISMATCH t=%0t run did not finish", $time);
        end_of_test();
    end

    initial begin
        clock = 1'b0;
        rst = 1'b1;
        nowTime = MISS;
        nowTick = 1'b0;
        seed = 32'd48;
        err_total = 0;
        compares = 0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        // outputs idle after reset
        check({5'h00, irq, alarmFlag, hourMode12}, 8'h00, "outputs after reset");
        // reset contents and an unmapped place
        i_cac_host_model.busWrite(8'h20, 8'hff);
        for (int i = 0; i < 7; i++) begin
            expRead(8'h10 + 8'(i), 8'h00);
        end
        expRead(8'h20, 8'h00);
        $display("reset values done");
        // random contents, back to back, unused bits dropped
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < 7; i++) begin
                seed = xs(seed);
                vals[i] = seed[7:0];
                i_cac_host_model.busWrite(8'h10 + 8'(i), seed[7:0]);
            end
            for (int i = 0; i < 7; i++) begin
                expRead(8'h10 + 8'(i), vals[i] & KEEP[i]);
            end
        end
        // write then read of the same register with no gap
        seed = xs(seed);
        i_cac_host_model.busWrite(`CAC_OFF_ALARM_WEEKDAY, seed[7:0]);
        expRead(`CAC_OFF_ALARM_WEEKDAY, seed[7:0] & KEEP[4]);
        i_cac_host_model.busWrite(`CAC_OFF_ALARM_YEAR, seed[15:8]);
        expRead(`CAC_OFF_ALARM_YEAR, seed[15:8] & KEEP[6]);
        $display("register fields done");
        // minutes, hour 0x21, weekday, year enabled; the rest disabled and wrong
        vals = '{8'h12, 8'hc5, 8'ha1, 8'h01, 8'h83, 8'h02, 8'ha4};
        for (int i = 0; i < 7; i++) begin
            i_cac_host_model.busWrite(8'h10 + 8'(i), vals[i]);
        end
        alarmRun(8'h03, 8'h01, 1'b1, 1'b1);
        alarmRun(8'h01, 8'h00, 1'b1, 1'b0);
        alarmRun(8'h00, 8'h01, 1'b0, 1'b0);
        i_cac_host_model.busIdle();
        @(posedge clock);
        end_of_test();
    end
endmodule
`default_nettype wire
